//--- sbcu_chk_properties.sv
// Port checker for the skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module sbcu_chk
  import sbcu_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        instr_valid,
  input wire sbcu_op_t    instr_op,
  input wire logic [2:0]  flag_index,
  input wire logic [6:0]  branch_offset,
  input wire logic        next_two_word,
  input wire logic        io_bit,
  input wire logic [7:0]  flags,
  input wire logic        pc_load,
  input wire logic        instr_ready,
  input wire logic [15:0] pc,
  input wire logic [1:0]  cycles,
  input wire logic        taken,
  input wire logic        skipped,
  input wire logic        retire,
  input wire logic        flags_write
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire        acc  = instr_valid && instr_ready && !pc_load;
  wire        fsel = flags[flag_index];
  wire [15:0] tgt  = pc + {{9{branch_offset[6]}}, branch_offset} + 16'h0001;
  a_no_flag_write: assert property (!flags_write)
    else $error("flags written");
  a_skip_low: assert property (acc && instr_op == SBCU_OP_SKIP_LOW && !io_bit
    |=> skipped && pc == $past(pc) + 16'h0002 + $past(next_two_word)) else $error("skip low");
  a_skip_high: assert property (acc && instr_op == SBCU_OP_SKIP_HIGH && io_bit
    |=> skipped && pc == $past(pc) + 16'h0002 + $past(next_two_word)) else $error("skip high");
  a_flag_set: assert property (acc && instr_op == SBCU_OP_BR_SET && fsel
    |=> taken && pc == $past(tgt)) else $error("flag set branch");
  a_flag_clear: assert property (acc && instr_op == SBCU_OP_BR_CLEAR
    |=> taken == !$past(fsel)) else $error("flag clear branch");
  a_null_branch: assert property (acc && instr_op inside {SBCU_OP_BR_EQ, SBCU_OP_BR_NE}
    |=> taken == ($past(flags[1]) ^ ($past(instr_op) == SBCU_OP_BR_NE))) else $error("null branch");
  a_carry_branch: assert property (acc && instr_op inside {SBCU_OP_BR_CS, SBCU_OP_BR_CC}
    |=> taken == ($past(flags[0]) ^ ($past(instr_op) == SBCU_OP_BR_CC))) else $error("carry branch");
  a_cycle_count: assert property (acc |=> cycles == (taken ? 2'h2 :
    (skipped ? 2'h2 + $past(next_two_word) : 2'h1))) else $error("cycle count");
  a_skip_wait: assert property (acc ##1 cycles == 2'h3
    |-> !instr_ready [*2] ##1 (instr_ready && retire)) else $error("three cycle wait");
  a_two_cycle: assert property (acc ##1 cycles == 2'h2
    |-> !instr_ready ##1 (instr_ready && retire)) else $error("two cycle wait");
  c_taken: cover property (acc ##1 taken);
  c_skip_two: cover property (acc ##1 (skipped && cycles == 2'h3));
  c_load: cover property (pc_load);
endmodule
bind sbcu_top sbcu_chk u_chk (.*);
`default_nettype wire

//--- sbcu_cond.sv
// Condition evaluation for skip and branch instructions
`timescale 1ns/1ps
`default_nettype none
`include "sbcu_map.svh"

module sbcu_cond
  import sbcu_pkg::*;
(
  input  wire sbcu_op_t    op,
  input  wire logic        io_bit,
  input  wire logic [7:0]  flags,
  input  wire logic [2:0]  flag_index,
  output logic             is_skip,
  output logic             is_branch,
  output logic             cond_true
);

  logic sel_flag;
  logic null_flag;
  logic carry_flag;

  assign sel_flag   = flags[flag_index];
  assign null_flag  = flags[`SBCU_FLAG_NULL];
  assign carry_flag = flags[`SBCU_FLAG_CARRY];

  always_comb begin
    is_skip   = 1'b0;
    is_branch = 1'b0;
    cond_true = 1'b0;
    unique case (op)
      SBCU_OP_SKIP_LOW: begin
        is_skip   = 1'b1;
        cond_true = ~io_bit;
      end
      SBCU_OP_SKIP_HIGH: begin
        is_skip   = 1'b1;
        cond_true = io_bit;
      end
      SBCU_OP_BR_SET: begin
        is_branch = 1'b1;
        cond_true = sel_flag;
      end
      SBCU_OP_BR_CLEAR: begin
        is_branch = 1'b1;
        cond_true = ~sel_flag;
      end
      SBCU_OP_BR_EQ: begin
        is_branch = 1'b1;
        cond_true = null_flag;
      end
      SBCU_OP_BR_NE: begin
        is_branch = 1'b1;
        cond_true = ~null_flag;
      end
      SBCU_OP_BR_CS: begin
        is_branch = 1'b1;
        cond_true = carry_flag;
      end
      SBCU_OP_BR_CC: begin
        is_branch = 1'b1;
        cond_true = ~carry_flag;
      end
      SBCU_OP_NONE: begin
        cond_true = 1'b0;
      end
      default: begin
        cond_true = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

//--- sbcu_io_space.sv
// I/O register space model serving the addressed bit
`timescale 1ns/1ps
`default_nettype none
module sbcu_io_space (
  input  wire logic [7:0] port_val,
  input  wire logic [2:0] bit_sel,
  output logic            io_bit
);
  assign io_bit = port_val[bit_sel];
endmodule
`default_nettype wire

//--- sbcu_map.svh
// Constants for the skip and branch condition unit
`ifndef SBCU_MAP_SVH
`define SBCU_MAP_SVH

// Widths
`define SBCU_PC_W        16
`define SBCU_OFS_W       7
`define SBCU_FLAGS_W     8
`define SBCU_FIDX_W      3
`define SBCU_CYC_W       2

// Reset values
`define SBCU_PC_RST      16'h0000
`define SBCU_CYC_RST     2'h0

// Field positions inside the processor flags register
`define SBCU_FLAG_CARRY  3'h0
`define SBCU_FLAG_NULL   3'h1

// Program counter steps
`define SBCU_STEP_SEQ    16'h0001
`define SBCU_STEP_SKIP1  16'h0002
`define SBCU_STEP_SKIP2  16'h0003
`define SBCU_STEP_BRANCH 16'h0001

// Execution cycle counts
`define SBCU_CYC_ONE     2'h1
`define SBCU_CYC_TWO     2'h2
`define SBCU_CYC_THREE   2'h3

`endif

//--- sbcu_pkg.sv
// Types shared by the skip and branch condition unit
package sbcu_pkg;

  typedef enum logic [3:0] {
    SBCU_OP_NONE      = 4'h0,
    SBCU_OP_SKIP_LOW  = 4'h1,
    SBCU_OP_SKIP_HIGH = 4'h2,
    SBCU_OP_BR_SET    = 4'h3,
    SBCU_OP_BR_CLEAR  = 4'h4,
    SBCU_OP_BR_EQ     = 4'h5,
    SBCU_OP_BR_NE     = 4'h6,
    SBCU_OP_BR_CS     = 4'h7,
    SBCU_OP_BR_CC     = 4'h8
  } sbcu_op_t;

  // Unsigned aliases share the carry encodings
  localparam sbcu_op_t SBCU_OP_BR_LOWER = SBCU_OP_BR_CS;
  localparam sbcu_op_t SBCU_OP_BR_SAME_OR_HIGHER = SBCU_OP_BR_CC;

  typedef enum logic [1:0] {
    SBCU_ST_READY = 2'b01,
    SBCU_ST_HOLD  = 2'b10
  } sbcu_state_t;

  // Sign-extend the 7-bit relative offset to program counter width
  function automatic logic [15:0] sbcu_sext(input logic [6:0] ofs);
    sbcu_sext = {{9{ofs[6]}}, ofs};
  endfunction

endpackage

//--- sbcu_top.sv
// Skip and conditional branch unit: condition, next program counter, cycle count
`timescale 1ns/1ps
`default_nettype none
`include "sbcu_map.svh"

module sbcu_top
  import sbcu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        instr_valid,
  input  wire sbcu_op_t    instr_op,
  input  wire logic [2:0]  flag_index,
  input  wire logic [6:0]  branch_offset,
  input  wire logic        next_two_word,
  input  wire logic        io_bit,
  input  wire logic [7:0]  flags,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_load_value,
  output logic             instr_ready,
  output logic [15:0]      pc,
  output logic [1:0]       cycles,
  output logic             taken,
  output logic             skipped,
  output logic             retire,
  output logic             flags_write
);

  sbcu_state_t state;
  sbcu_state_t next_state;
  logic [1:0]  remain;
  logic [1:0]  next_remain;
  logic        accept;
  logic        is_skip;
  logic        is_branch;
  logic        cond_true;
  logic [15:0] next_pc;
  logic [1:0]  next_cycles;
  logic [15:0] branch_step;

  // Program counter plus a step, wrapping modulo the counter width
  function automatic logic [15:0] sbcu_pc_add(input logic [15:0] base,
                                              input logic [15:0] step);
    sbcu_pc_add = base + step;
  endfunction

  // True for a count that needs no cycle beyond its accept edge
  function automatic logic sbcu_single(input logic [1:0] count);
    sbcu_single = (count == `SBCU_CYC_ONE);
  endfunction

  sbcu_cond u_cond (
    .op         (instr_op),
    .io_bit     (io_bit),
    .flags      (flags),
    .flag_index (flag_index),
    .is_skip    (is_skip),
    .is_branch  (is_branch),
    .cond_true  (cond_true)
  );

  // New instructions are taken only once the previous one has used its cycles
  assign instr_ready = (state == SBCU_ST_READY);
  assign accept      = instr_valid & instr_ready;

  // Relative branch distance: signed offset plus one
  assign branch_step = sbcu_sext(branch_offset) + `SBCU_STEP_BRANCH;

  // Target of the instruction being accepted
  always_comb begin
    next_pc = sbcu_pc_add(pc, `SBCU_STEP_SEQ);
    if (is_skip && cond_true) begin
      if (next_two_word) begin
        next_pc = sbcu_pc_add(pc, `SBCU_STEP_SKIP2);
      end else begin
        next_pc = sbcu_pc_add(pc, `SBCU_STEP_SKIP1);
      end
    end else if (is_branch && cond_true) begin
      next_pc = sbcu_pc_add(pc, branch_step);
    end
  end

  // Execution length of the instruction being accepted
  always_comb begin
    next_cycles = `SBCU_CYC_ONE;
    if (cond_true && is_skip) begin
      next_cycles = next_two_word ? `SBCU_CYC_THREE : `SBCU_CYC_TWO;
    end else if (cond_true && is_branch) begin
      next_cycles = `SBCU_CYC_TWO;
    end
  end

  // Sequencer holding the unit busy for the extra cycles
  always_comb begin
    next_state  = state;
    next_remain = remain;
    unique case (state)
      SBCU_ST_READY: begin
        if (accept && !sbcu_single(next_cycles)) begin
          next_state  = SBCU_ST_HOLD;
          next_remain = next_cycles - `SBCU_CYC_ONE;
        end
      end
      SBCU_ST_HOLD: begin
        next_remain = remain - `SBCU_CYC_ONE;
        if (sbcu_single(remain)) begin
          next_state = SBCU_ST_READY;
        end
      end
      default: begin
        next_state  = SBCU_ST_READY;
        next_remain = `SBCU_CYC_RST;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state  <= SBCU_ST_READY;
      remain <= `SBCU_CYC_RST;
    end else begin
      state  <= next_state;
      remain <= next_remain;
    end
  end

  // Program counter; an external load wins so other instructions can redirect
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pc <= `SBCU_PC_RST;
    end else if (pc_load) begin
      pc <= pc_load_value;
    end else if (accept) begin
      pc <= next_pc;
    end
  end

  // Outcome of the most recent accepted instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cycles  <= `SBCU_CYC_RST;
      taken   <= 1'b0;
      skipped <= 1'b0;
    end else if (accept) begin
      cycles  <= next_cycles;
      taken   <= is_branch & cond_true;
      skipped <= is_skip & cond_true;
    end
  end

  // One-cycle pulse in the cycle after the last cycle of each instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      retire <= 1'b0;
    end else begin
      retire <= (accept && sbcu_single(next_cycles)) ||
                ((state == SBCU_ST_HOLD) && sbcu_single(remain));
    end
  end

  // These instructions never write the flags
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_write <= 1'b0;
    end else begin
      flags_write <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking testbench for the skip and branch unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sbcu_pkg::*;
;
  logic        clk = 0, arst_n = 0, instr_valid = 0, next_two_word = 0, pc_load = 0;
  logic        io_bit, instr_ready, taken, skipped, retire, flags_write;
  sbcu_op_t    instr_op = SBCU_OP_NONE;
  logic [2:0]  flag_index = 3'h0;
  logic [6:0]  branch_offset = 7'h00;
  logic [7:0]  flags = 8'h00;
  logic [15:0] pc_load_value = 16'h0000, mpc = 16'h0000, pc;
  logic [1:0]  cycles;
  int          miscompares = 0, num_checks = 0;
  sbcu_top dut (.clk, .arst_n, .instr_valid, .instr_op, .flag_index, .branch_offset,
    .next_two_word, .io_bit, .flags, .pc_load, .pc_load_value, .instr_ready, .pc,
    .cycles, .taken, .skipped, .retire, .flags_write);
  sbcu_io_space io (.port_val(flags), .bit_sel(flag_index), .io_bit);
  always #2.5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Offers one instruction; checks new PC, cycle count and retire timing
  task automatic go(input sbcu_op_t op, input logic [2:0] fi, input logic [6:0] k,
                    input logic tw, input logic [7:0] fl, input logic [15:0] st,
                    input logic [1:0] cy);
    @(posedge clk);
    instr_op <= op;
    flag_index <= fi;
    branch_offset <= k;
    next_two_word <= tw;
    flags <= fl;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    mpc = mpc + st;
    check(pc, mpc);
    check(16'(cycles), 16'(cy));
    repeat (cy - 1) @(posedge clk);
    #1;
    check(16'(retire), 16'h0001);
    check(16'(flags_write), 16'h0000);
  endtask
  task automatic t_skip();
    logic s;
    for (int i = 0; i < 8; i++) begin
      s = (i[0] == i[1]);
      go(i[1] ? SBCU_OP_SKIP_HIGH : SBCU_OP_SKIP_LOW, 3'h2, 7'h00, i[2],
         i[0] ? 8'h04 : 8'hFB, s ? 16'h0002 + i[2] : 16'h0001, s ? 2'h2 + i[2] : 2'h1);
    end
  endtask
  task automatic t_flag();
    go(SBCU_OP_BR_SET, 3'h5, 7'h7F, 1'b0, 8'h20, 16'h0000, 2'h2);
    go(SBCU_OP_BR_SET, 3'h5, 7'h7F, 1'b0, 8'hDF, 16'h0001, 2'h1);
    go(SBCU_OP_BR_CLEAR, 3'h6, 7'h3F, 1'b0, 8'hBF, 16'h0040, 2'h2);
    go(SBCU_OP_BR_CLEAR, 3'h6, 7'h3F, 1'b0, 8'h40, 16'h0001, 2'h1);
  endtask
  // Equal, not equal, carry set, carry clear, each with its flag at 1 then 0
  task automatic t_fixed();
    logic t;
    for (int i = 0; i < 8; i++) begin
      t = (i[0] == i[1]);
      go(sbcu_op_t'(4'h5 + 4'(i / 2)), 3'h0, 7'h40, 1'b0, i[0] ? 8'hFC : 8'h03,
         t ? 16'hFFC1 : 16'h0001, t ? 2'h2 : 2'h1);
    end
  endtask
  task automatic t_wrap();
    @(posedge clk);
    pc_load <= 1'b1;
    pc_load_value <= 16'hFFFF;
    @(posedge clk);
    pc_load <= 1'b0;
    #1;
    mpc = 16'hFFFF;
    check(pc, mpc);
    go(sbcu_op_t'(4'hF), 3'h0, 7'h00, 1'b0, 8'h00, 16'h0001, 2'h1);
    check(pc, 16'h0000);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    check(pc, 16'h0000);
    t_skip();
    t_flag();
    t_fixed();
    t_wrap();
    wrap_up();
  end
  initial begin
    #5000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
